/* File: pkg/tcc_pkg.sv */
// Register map, field layout and encodings of the timer capture/compare block
package tcc_pkg;
  localparam logic [7:0] TCC_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCC_OFS_CNT = 8'h04;
  localparam logic [7:0] TCC_OFS_MOD = 8'h08;
  localparam logic [7:0] TCC_OFS_INIT = 8'h0c;
  localparam logic [7:0] TCC_OFS_STAT = 8'h10;
  localparam logic [7:0] TCC_OFS_INTEN = 8'h14;
  localparam logic [7:0] TCC_OFS_SWOC = 8'h18;
  localparam logic [7:0] TCC_OFS_PAIR = 8'h1c;
  localparam logic [7:0] TCC_OFS_DEAD = 8'h20;
  localparam logic [7:0] TCC_OFS_FILT = 8'h24;
  localparam logic [7:0] TCC_OFS_CH = 8'h40;
  localparam logic [15:0] TCC_MOD_RST = 16'hffff;
  // Per-pair control byte
  localparam int TCC_PB_COMP = 0;
  localparam int TCC_PB_DT = 1;
  localparam int TCC_PB_FAULT = 2;
  localparam int TCC_PB_INV = 3;
  localparam int TCC_PB_DUAL = 4;
  localparam int TCC_PB_CONT = 5;
  localparam int TCC_PB_ARM = 6;
  localparam int TCC_STAT_OVF = 8;
  typedef enum logic [1:0] {TCC_SRC_OFF, TCC_SRC_SYS, TCC_SRC_FIX, TCC_SRC_EXT} tcc_src_e;
  typedef enum logic [1:0] {TCC_ACT_NONE, TCC_ACT_TOGGLE, TCC_ACT_LOW, TCC_ACT_HIGH} tcc_act_e;
  typedef enum logic [1:0] {TCC_MODE_CAPT, TCC_MODE_COMP, TCC_MODE_IDLE, TCC_MODE_IDLE2} tcc_mode_e;
  typedef enum logic [1:0] {TCC_ELS_NONE, TCC_ELS_LOW, TCC_ELS_HIGH, TCC_ELS_HIGH2} tcc_els_e;
  typedef enum logic [1:0] {TCC_DTP_1, TCC_DTP_1B, TCC_DTP_4, TCC_DTP_16} tcc_dtp_e;
  localparam logic [3:0] TCC_DTSH_4 = 4'h2;
  localparam logic [3:0] TCC_DTSH_16 = 4'h4;
endpackage

/* File: hdl/tcc_top.sv */
// Timer capture/compare channels with AHB-Lite register slave
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tcc_top #(
  parameter int NCH = 8,
  parameter int NFILT = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] ch_in,
  input wire logic fixed_clk_in,
  input wire logic ext_clk_in,
  input wire logic fault_n,
  output logic [7:0] ch_out,
  output logic [7:0] ch_oe
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [7:0] s1_ch;
    logic [7:0] s2_ch;
    logic [2:0] s1_x;
    logic [2:0] s2_x;
    logic [1:0] x_prev;
    logic [6:0] psc;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic [15:0] init;
    logic [4:0] ctrl;
    logic [8:0] stat;
    logic [8:0] inten;
    logic [7:0] swen;
    logic [7:0] swval;
    logic [31:0] pair;
    logic [7:0] dead;
    logic [15:0] filt;
    logic [7:0][7:0] csc;
    logic [7:0][15:0] cv;
    logic [7:0] out;
    logic [3:0][3:0] fcnt;
    logic [3:0] fval;
    logic [7:0] lvp;
    logic [3:0] second;
    logic [3:0][9:0] dtcnt;
    logic [3:0] pa;
    logic [7:0] pin;
    logic [7:0] oe;
    logic [7:0] ad_addr;
    logic wr_pend;
    logic rd_wait;
    logic [31:0] rdata;
  } tcc_state_s;

  tcc_state_s s_r, s_nxt;
  logic tick;
  logic [7:0] lv;
  logic [7:0] cap;
  logic [7:0] po;
  logic [3:0] dt_hold;

  function automatic logic [31:0] rd_mux(input tcc_state_s s, input logic [7:0] a);
    logic [31:0] v;
    int i;
    v = 32'h0;
    i = int'(a[6:3]);
    if (a == TCC_OFS_CTRL) v = {27'h0, s.ctrl};
    else if (a == TCC_OFS_CNT) v = {16'h0, s.cnt};
    else if (a == TCC_OFS_MOD) v = {16'h0, s.modv};
    else if (a == TCC_OFS_INIT) v = {16'h0, s.init};
    else if (a == TCC_OFS_STAT) v = {23'h0, s.stat};
    else if (a == TCC_OFS_INTEN) v = {23'h0, s.inten};
    else if (a == TCC_OFS_SWOC) v = {16'h0, s.swval, s.swen};
    else if (a == TCC_OFS_PAIR) v = s.pair;
    else if (a == TCC_OFS_DEAD) v = {24'h0, s.dead};
    else if (a == TCC_OFS_FILT) v = {16'h0, s.filt};
    else if (a >= TCC_OFS_CH && i >= 8 && i < NCH + 8) begin
      v = a[2] ? {16'h0, s.cv[i-8]} : {24'h0, s.csc[i-8]};
    end
    return v;
  endfunction

  always_comb begin
    tcc_state_s s;
    logic src_edge;
    logic [6:0] pmask;
    logic [7:0] clr;
    logic [8:0] set;
    logic fault_act;
    logic a, b, x;
    logic [9:0] dtload;
    logic rise, fall, hit, src_lv, src_lp;
    int p, k;
    s = s_r;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    src_lv = 1'b0;
    src_lp = 1'b0;
    p = 0;
    k = 0;
    src_edge = 1'b0;
    pmask = 7'h0;
    clr = 8'h0;
    set = 9'h0;
    tick = 1'b0;
    lv = 8'h0;
    cap = 8'h0;
    po = 8'h0;
    dt_hold = 4'h0;
    fault_act = 1'b0;
    a = 1'b0;
    b = 1'b0;
    x = 1'b0;
    dtload = 10'h0;
    s.s1_ch = ch_in;
    s.s2_ch = s_r.s1_ch;
    s.s1_x = {fault_n, ext_clk_in, fixed_clk_in};
    s.s2_x = s_r.s1_x;
    s.x_prev = s_r.s2_x[1:0];
    fault_act = !s_r.s2_x[2];

    case (tcc_src_e'(s_r.ctrl[1:0]))
      TCC_SRC_SYS: src_edge = 1'b1;
      TCC_SRC_FIX: src_edge = s_r.s2_x[0] & ~s_r.x_prev[0];
      TCC_SRC_EXT: src_edge = s_r.s2_x[1] & ~s_r.x_prev[1];
      default: src_edge = 1'b0;
    endcase
    pmask = 7'((8'h01 << s_r.ctrl[4:2]) - 8'h01);
    if (tcc_src_e'(s_r.ctrl[1:0]) == TCC_SRC_OFF) begin
      s.psc = 7'h0;
    end else if (src_edge) begin
      if (s_r.psc >= pmask) begin
        s.psc = 7'h0;
        tick = 1'b1;
      end else begin
        s.psc = s_r.psc + 7'h01;
      end
    end
    // wrap at modulo back to start
    if (tick) begin
      if (s_r.cnt == s_r.modv) begin
        // range bounded by start and modulo
        s.cnt = s_r.init;
        set[TCC_STAT_OVF] = 1'b1;
      end else begin
        s.cnt = s_r.cnt + 16'h0001;
      end
    end

    for (k = 0; k < NCH; k++) begin
      lv[k] = s_r.s2_ch[k];
      if (k < NFILT) begin
        if (s_r.s2_ch[k] == s_r.fval[k]) begin
          s.fcnt[k] = 4'h0;
        end else if (s_r.fcnt[k] >= s_r.filt[k*4 +: 4]) begin
          s.fval[k] = s_r.s2_ch[k];
          s.fcnt[k] = 4'h0;
        end else begin
          s.fcnt[k] = s_r.fcnt[k] + 4'h1;
        end
        if (s_r.filt[k*4 +: 4] != 4'h0) lv[k] = s_r.fval[k];
      end
    end
    s.lvp = lv;

    for (k = 0; k < NCH; k++) begin
      p = k / 2;
      // pair input is the even channel
      src_lv = s_r.pair[p*8 + TCC_PB_DUAL] ? lv[2*p] : lv[k];
      src_lp = s_r.pair[p*8 + TCC_PB_DUAL] ? s_r.lvp[2*p] : s_r.lvp[k];
      rise = src_lv & ~src_lp;
      fall = ~src_lv & src_lp;
      hit = (s_r.csc[k][3] & rise) | (s_r.csc[k][2] & fall);
      if (s_r.pair[p*8 + TCC_PB_DUAL]) begin
        // first edge even channel, second odd
        if (s_r.pair[p*8 + TCC_PB_ARM] && (k[0] == s_r.second[p]) && hit) begin
          cap[k] = 1'b1;
        end
      end else if (tcc_mode_e'(s_r.csc[k][1:0]) == TCC_MODE_CAPT) begin
        cap[k] = hit;
      end else if (tcc_mode_e'(s_r.csc[k][1:0]) == TCC_MODE_COMP && tick && s_r.cnt == s_r.cv[k]) begin
        set[k] = 1'b1;
        case (tcc_act_e'(s_r.csc[k][5:4]))
          TCC_ACT_TOGGLE: s.out[k] = ~s_r.out[k];
          TCC_ACT_LOW: s.out[k] = 1'b0;
          TCC_ACT_HIGH: s.out[k] = 1'b1;
          default: s.out[k] = s_r.out[k];
        endcase
      end
      if (cap[k]) begin
        s.cv[k] = s_r.cnt;
        set[k] = 1'b1;
      end
    end
    // four pairs sequence their dual-edge state
    for (p = 0; p < NCH / 2; p++) begin
      if (cap[2*p]) s.second[p] = 1'b1;
      if (cap[2*p+1]) begin
        s.second[p] = 1'b0;
        if (!s_r.pair[p*8 + TCC_PB_CONT]) s.pair[p*8 + TCC_PB_ARM] = 1'b0;
      end
      if (!s_r.pair[p*8 + TCC_PB_DUAL]) s.second[p] = 1'b0;
    end

    // Pair output shaping
    case (tcc_dtp_e'(s_r.dead[7:6]))
      TCC_DTP_4: dtload = {4'h0, s_r.dead[5:0]} << TCC_DTSH_4;
      TCC_DTP_16: dtload = {4'h0, s_r.dead[5:0]} << TCC_DTSH_16;
      default: dtload = {4'h0, s_r.dead[5:0]};
    endcase
    for (p = 0; p < NCH / 2; p++) begin
      a = s_r.out[2*p];
      b = s_r.pair[p*8 + TCC_PB_COMP] ? ~a : s_r.out[2*p+1];
      po[2*p] = a;
      po[2*p+1] = b;
      s.pa[p] = a;
      // dead time on each edge of the pair's even output
      if (s_r.pair[p*8 + TCC_PB_DT] && a != s_r.pa[p]) begin
        s.dtcnt[p] = dtload;
      end else if (s_r.dtcnt[p] != 10'h0) begin
        s.dtcnt[p] = s_r.dtcnt[p] - 10'h001;
      end
      dt_hold[p] = s_r.pair[p*8 + TCC_PB_DT] && s_r.dtcnt[p] != 10'h0;
      for (k = 2*p; k < 2*p + 2; k++) begin
        x = dt_hold[p] ? 1'b0 : po[k];
        if (s_r.pair[p*8 + TCC_PB_INV]) x = ~x;
        if (s_r.pair[p*8 + TCC_PB_FAULT] && fault_act) x = 1'b0;
        case (tcc_els_e'(s_r.csc[k][7:6]))
          TCC_ELS_NONE: begin
            s.pin[k] = 1'b0;
            s.oe[k] = 1'b0;
          end
          TCC_ELS_LOW: begin
            s.pin[k] = ~x;
            s.oe[k] = 1'b1;
          end
          default: begin
            s.pin[k] = x;
            s.oe[k] = 1'b1;
          end
        endcase
        if (s_r.swen[k]) begin
          s.pin[k] = s_r.swval[k];
          s.oe[k] = 1'b1;
        end
      end
    end

    // Bus: address phase
    s.wr_pend = 1'b0;
    s.rd_wait = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s.ad_addr = haddr[7:0];
      s.wr_pend = hwrite;
      s.rd_wait = !hwrite;
    end
    // Reads wait one cycle so an earlier write is always seen
    if (s_r.rd_wait) s.rdata = rd_mux(s_r, s_r.ad_addr);

    // Bus: data phase write, after hardware updates
    if (s_r.wr_pend) begin
      k = int'(s_r.ad_addr[6:3]) - 8;
      case (s_r.ad_addr)
        TCC_OFS_CTRL: s.ctrl = hwdata[4:0];
        TCC_OFS_CNT: s.cnt = s_r.init;
        TCC_OFS_MOD: s.modv = hwdata[15:0];
        TCC_OFS_INIT: s.init = hwdata[15:0];
        TCC_OFS_STAT: clr = hwdata[7:0];
        TCC_OFS_INTEN: s.inten = hwdata[8:0];
        TCC_OFS_SWOC: begin
          s.swen = hwdata[7:0];
          s.swval = hwdata[15:8];
        end
        TCC_OFS_PAIR: s.pair = hwdata;
        TCC_OFS_DEAD: s.dead = hwdata[7:0];
        TCC_OFS_FILT: s.filt = hwdata[15:0];
        default: begin
          if (s_r.ad_addr >= TCC_OFS_CH && k >= 0 && k < NCH) begin
            if (s_r.ad_addr[2]) s.cv[k] = hwdata[15:0];
            else s.csc[k] = hwdata[7:0];
          end
        end
      endcase
      if (s_r.ad_addr == TCC_OFS_STAT) s.stat = (s_r.stat & ~{hwdata[8], clr}) | set;
      else s.stat = s_r.stat | set;
    end else begin
      s.stat = s_r.stat | set;
    end
    s_nxt = s;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.modv <= TCC_MOD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = !s_r.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign ch_out = s_r.pin;
  assign ch_oe = s_r.oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence rd_accept;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait: assert property (rd_accept |=> rd_answer)
    else $error("read data phase not one wait state");
  chk_cnt_wrap: assert property (tick && s_r.cnt == s_r.modv && !s_r.wr_pend |=> s_r.cnt == $past(s_r.init))
    else $error("counter did not wrap to start value");
  chk_cnt_stop: assert property (s_r.ctrl[1:0] == 2'h0 && !s_r.wr_pend |=> $stable(s_r.cnt))
    else $error("counter moved with no clock source");
  chk_hi_nofilter: assert property (lv[7:4] == s_r.s2_ch[7:4])
    else $error("high channel input was filtered");
  chk_filt_bypass: assert property (s_r.filt[3:0] == 4'h0 |-> lv[0] == s_r.s2_ch[0])
    else $error("zero filter setting did not bypass");
  chk_capture_val: assert property (cap[0] && !s_r.wr_pend |=> s_r.cv[0] == $past(s_r.cnt) && s_r.stat[0])
    else $error("capture did not store count and flag");
  chk_sw_force: assert property (s_r.swen[3] |=> ch_out[3] == $past(s_r.swval[3]) && ch_oe[3])
    else $error("software override not on pin");
  chk_comp_pair: assert property (s_r.pair[TCC_PB_COMP] |-> po[1] == !po[0])
    else $error("pair not complementary");
  chk_dead_gap: assert property (dt_hold[0] && !s_r.pair[TCC_PB_INV] && !s_r.swen[0]
    && s_r.csc[0][7:6] == 2'h2 |=> !ch_out[0])
    else $error("output active inside dead time");
  chk_cmp_toggle: assert property (tick && s_r.csc[1][1:0] == 2'h1 && s_r.csc[1][5:4] == 2'h1
    && s_r.cnt == s_r.cv[1] && !s_r.pair[TCC_PB_DUAL] |=> s_r.out[1] != $past(s_r.out[1]))
    else $error("compare toggle missing");
endmodule

/* File: verification/tcc_ext.sv */
// Model of the pins beyond the timer: capture inputs, count sources, fault line
`timescale 1ns/1ps
module tcc_ext (
  input wire logic hclk,
  input wire logic [7:0] ch_out,
  input wire logic [7:0] ch_oe,
  output logic [7:0] ch_in,
  output logic fixed_clk_in,
  output logic ext_clk_in,
  output logic fault_n
);
  logic [2:0] div_r = 3'h0;
  initial begin
    ch_in = 8'h00;
    fault_n = 1'b1;
  end
  // Count sources run free, unrelated to bus traffic
  always @(posedge hclk) div_r <= div_r + 3'h1;
  assign fixed_clk_in = div_r[2];
  assign ext_clk_in = div_r[1];
  // Lines are held at a level for a number of cycles
  task automatic set_in(input int ch, input logic v, input int hold);
    ch_in[ch] <= v;
    repeat (hold) @(posedge hclk);
  endtask
  task automatic set_fault(input logic v);
    fault_n <= v;
  endtask
endmodule

/* File: verification/tcc_top_tb.sv */
// Self-checking bench for the timer capture/compare block
`timescale 1ns/1ps
module tcc_top_tb;
  import tcc_pkg::*;
  typedef struct {logic [31:0] lo; logic [31:0] hi;} tcc_exp_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fixed_clk_in, ext_clk_in, fault_n, dph_rd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ch_in, ch_out, ch_oe;
  logic [15:0] r0, r1;
  int err_count, n_checks;
  tcc_exp_s exp_q[$];

  tcc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ch_in(ch_in), .fixed_clk_in(fixed_clk_in),
    .ext_clk_in(ext_clk_in), .fault_n(fault_n), .ch_out(ch_out), .ch_oe(ch_oe));
  tcc_ext i_ext (.hclk(hclk), .ch_out(ch_out), .ch_oe(ch_oe), .ch_in(ch_in),
    .fixed_clk_in(fixed_clk_in), .ext_clk_in(ext_clk_in), .fault_n(fault_n));

  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Entered just after a rising edge; hreadyout is read before that edge's updates land
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    exp_q.push_back('{lo, hi});
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic pin(input int ch, input logic v);
    repeat (8) @(posedge hclk);
    n_checks++;
    if (ch_out[ch] !== v || ch_oe[ch] !== 1'b1) bad("channel pin level");
  endtask
  task automatic glitch(input int ch);
    i_ext.set_in(ch, 1'b1, 3);
    i_ext.set_in(ch, 1'b0, 24);
  endtask

  // Read data checked against the oldest note when the data phase completes
  always @(posedge hclk) begin
    if (hresp !== 1'b0) bad("error response");
    if (dph_rd && hreadyout === 1'b1) begin
      n_checks++;
      if (exp_q.size() == 0) bad("read without note");
      else begin
        if ((hrdata >= exp_q[0].lo && hrdata <= exp_q[0].hi) !== 1'b1) bad("read data");
        void'(exp_q.pop_front());
      end
    end
    if (!hresetn) dph_rd <= 1'b0;
    else if (hreadyout === 1'b1) dph_rd <= hsel && htrans[1] && !hwrite;
  end

  initial begin
    #60000;
    bad("timeout");
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(53));
    r0 = 16'($urandom());
    r1 = ~r0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(TCC_OFS_MOD, 32'hffff, 32'hffff);
    rd(TCC_OFS_CTRL, 32'h0, 32'h0);
    rd(8'h30, 32'h0, 32'h0);
    wr(TCC_OFS_INTEN, 32'h1a5);
    rd(TCC_OFS_INTEN, 32'h1a5, 32'h1a5);
    wr(TCC_OFS_INTEN, 32'h05a);
    rd(TCC_OFS_INTEN, 32'h05a, 32'h05a);
    // Counter stopped, so every capture sees a known count
    wr(TCC_OFS_INIT, {16'h0, r0});
    wr(TCC_OFS_CNT, 32'h0);
    rd(TCC_OFS_CNT, {16'h0, r0}, {16'h0, r0});
    wr(TCC_OFS_CH + 8'h20, 32'h08);
    i_ext.set_in(4, 1'b1, 8);
    wr(TCC_OFS_INIT, {16'h0, r1});
    wr(TCC_OFS_CNT, 32'h0);
    i_ext.set_in(4, 1'b0, 8);
    rd(TCC_OFS_CH + 8'h24, {16'h0, r0}, {16'h0, r0});
    rd(TCC_OFS_CNT, {16'h0, r1}, {16'h0, r1});
    rd(TCC_OFS_STAT, 32'h10, 32'h10);
    wr(TCC_OFS_STAT, 32'h10);
    rd(TCC_OFS_STAT, 32'h0, 32'h0);
    // Short glitch: filtered on channel 0, passes on channel 4
    wr(TCC_OFS_CH, 32'h0c);
    wr(TCC_OFS_FILT, 32'hffff);
    glitch(0);
    glitch(4);
    rd(TCC_OFS_CH + 8'h04, 32'h0, 32'h0);
    rd(TCC_OFS_CH + 8'h24, {16'h0, r1}, {16'h0, r1});
    wr(TCC_OFS_FILT, 32'h0);
    glitch(0);
    rd(TCC_OFS_CH + 8'h04, {16'h0, r1}, {16'h0, r1});
    // Running counter with a four-tick period
    wr(TCC_OFS_INIT, 32'h10);
    wr(TCC_OFS_MOD, 32'h13);
    wr(TCC_OFS_CNT, 32'h0);
    wr(TCC_OFS_CH + 8'h28, 32'hb1);
    wr(TCC_OFS_CH + 8'h2c, 32'h12);
    wr(TCC_OFS_CTRL, 32'h1);
    rd(TCC_OFS_CNT, 32'h10, 32'h13);
    pin(5, 1'b1);
    rd(TCC_OFS_STAT, 32'h100, 32'h1ff);
    wr(TCC_OFS_PAIR, 32'h0004_0000);
    i_ext.set_fault(1'b0);
    pin(5, 1'b0);
    i_ext.set_fault(1'b1);
    pin(5, 1'b1);
    wr(TCC_OFS_CH + 8'h28, 32'ha1);
    pin(5, 1'b0);
    wr(TCC_OFS_PAIR, 32'h0008_0000);
    pin(5, 1'b1);
    wr(TCC_OFS_CH + 8'h30, 32'h80);
    wr(TCC_OFS_SWOC, 32'h4848);
    rd(TCC_OFS_SWOC, 32'h4848, 32'h4848);
    pin(6, 1'b1);
    pin(3, 1'b1);
    // Low-true select inverts the idle level; no-output select releases the pin
    wr(TCC_OFS_SWOC, 32'h0);
    wr(TCC_OFS_CH + 8'h30, 32'h40);
    pin(6, 1'b1);
    n_checks++;
    if (ch_oe[4] !== 1'b0) bad("unselected output drives pin");
    // Pair 0 complementary, then dead time scaled by four
    wr(TCC_OFS_CH + 8'h0c, 32'h12);
    wr(TCC_OFS_CH + 8'h08, 32'h91);
    wr(TCC_OFS_CH + 8'h04, 32'h11);
    wr(TCC_OFS_CH, 32'hb1);
    wr(TCC_OFS_PAIR, 32'h1);
    pin(0, 1'b1);
    pin(1, 1'b0);
    wr(TCC_OFS_DEAD, 32'h90);
    wr(TCC_OFS_PAIR, 32'h3);
    wr(TCC_OFS_CH, 32'ha1);
    repeat (40) @(posedge hclk);
    pin(1, 1'b0);
    repeat (40) @(posedge hclk);
    pin(1, 1'b1);
    // Count sources: fixed pin, then external pin divided by four
    wr(TCC_OFS_MOD, 32'hffff);
    wr(TCC_OFS_CTRL, 32'h2);
    wr(TCC_OFS_CNT, 32'h0);
    repeat (80) @(posedge hclk);
    rd(TCC_OFS_CNT, 32'h19, 32'h1c);
    wr(TCC_OFS_CTRL, 32'hb);
    wr(TCC_OFS_CNT, 32'h0);
    repeat (80) @(posedge hclk);
    rd(TCC_OFS_CNT, 32'h14, 32'h17);
    wr(TCC_OFS_CTRL, 32'h0);
    wr(TCC_OFS_CNT, 32'h0);
    repeat (10) @(posedge hclk);
    rd(TCC_OFS_CNT, 32'h10, 32'h10);
    // Dual-edge pair 1, one-shot: rise into channel 2, fall into channel 3
    wr(TCC_OFS_CH + 8'h10, 32'h08);
    wr(TCC_OFS_CH + 8'h18, 32'h04);
    wr(TCC_OFS_PAIR, 32'h5000);
    i_ext.set_in(2, 1'b1, 8);
    wr(TCC_OFS_INIT, {16'h0, r0});
    wr(TCC_OFS_CNT, 32'h0);
    i_ext.set_in(2, 1'b0, 8);
    wr(TCC_OFS_INIT, {16'h0, r1});
    wr(TCC_OFS_CNT, 32'h0);
    i_ext.set_in(2, 1'b1, 8);
    rd(TCC_OFS_CH + 8'h14, 32'h10, 32'h10);
    rd(TCC_OFS_CH + 8'h1c, {16'h0, r0}, {16'h0, r0});
    rd(TCC_OFS_PAIR, 32'h1000, 32'h1000);
    repeat (2) @(posedge hclk);
    if (exp_q.size() != 0) bad("notes left over");
    end_of_test();
  end
endmodule
